// *** cs_decode_pkg.sv ***
package cs_decode_pkg;
  localparam int num_banks = 8;
  localparam int bank_idx_w = 3;
  // Register offsets within the block
  localparam logic [7:0] base_reg_first = 8'h80;
  localparam logic [7:0] bank_stride = 8'h0c;
  localparam logic [7:0] mask_reg_delta = 8'h04;
  // Mask register field positions
  localparam int base_mask_hi = 31;
  localparam int base_mask_lo = 16;
  localparam int write_protect_pos = 8;
  localparam int alternate_master_pos = 6;
  localparam int cpu_space_pos = 5;
  localparam int supervisor_code_pos = 4;
  localparam int supervisor_data_pos = 3;
  localparam int user_code_pos = 2;
  localparam int user_data_pos = 1;
  localparam int valid_pos = 0;
  // Writable bits of the mask register
  localparam logic [31:0] mask_reg_writable = 32'hffff_017f;
  localparam logic [15:0] base_reset = 16'h0000;
  localparam logic [31:0] mask_reset = 32'h0000_0000;

  // Access type presented with each bus access
  typedef enum logic [2:0] {
    acc_cpu_space,
    acc_super_code,
    acc_super_data,
    acc_user_code,
    acc_user_data
  } access_type_t;

  // One access on the internal bus
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic alt_master;
    access_type_t kind;
  } access_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

// *** cs_decode.sv ***
`timescale 1ns/1ns
module cs_decode (
  input wire logic clock,
  input wire logic nrst,
  input wire cs_decode_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  input wire cs_decode_pkg::access_t access,
  output logic [7:0] chip_select,
  output logic boot_global
);
  import cs_decode_pkg::*;

  logic [15:0] bank_base_address [num_banks]; // Base per bank
  logic [31:0] bank_mask_and_qualifiers [num_banks]; // Mask per bank
  logic [15:0] next_base [num_banks]; // Base after this cycle's write
  logic [31:0] next_mask [num_banks]; // Mask after this cycle's write
  logic global_mode; // Boot bank selects every access
  logic next_global; // Global mode after this cycle
  logic [31:0] next_rdata; // Read data for the next cycle
  logic [7:0] hit; // Per-bank full decode match
  logic [7:0] next_cs; // Selects for the next cycle

  // Offset of a bank's base register
  function automatic logic [7:0] base_off(input int b);
    return 8'(base_reg_first + 8'(b) * bank_stride);
  endfunction

  // Space mask bit position for an access type
  function automatic int space_pos(input access_type_t k);
    unique case (k)
      acc_cpu_space: return cpu_space_pos;
      acc_super_code: return supervisor_code_pos;
      acc_super_data: return supervisor_data_pos;
      acc_user_code: return user_code_pos;
      // Illegal codes fall back to user data
      default: return user_data_pos;
    endcase
  endfunction

  // Register writes and global mode tracking
  always_comb begin
    next_global = global_mode;
    // Each bank has a base slot and a mask slot
    for (int b = 0; b < num_banks; b++) begin
      // Hold unless addressed
      next_base[b] = bank_base_address[b];
      next_mask[b] = bank_mask_and_qualifiers[b];
      // Base field sits in the upper half of the word
      if (reg_req.wr && reg_req.addr == base_off(b)) begin
        next_base[b] = reg_req.wdata[31:16];
      end
      // Reserved mask bits never store
      if (reg_req.wr && reg_req.addr == 8'(base_off(b) + mask_reg_delta))
      begin
        next_mask[b] = reg_req.wdata & mask_reg_writable;
      end
    end
    // Leaving global mode only; return needs reset
    if (next_mask[0][valid_pos]) begin
      next_global = 1'b0;
    end
  end

  // Register readback
  always_comb begin
    // Unmapped offsets read as zero
    next_rdata = 32'h0000_0000;
    for (int b = 0; b < num_banks; b++) begin
      if (reg_req.rd && reg_req.addr == base_off(b)) begin
        // Base fills the upper half, lower half zero
        next_rdata = {bank_base_address[b], 16'h0000};
      end
      if (reg_req.rd && reg_req.addr == 8'(base_off(b) + mask_reg_delta))
      begin
        // Mask reads back as stored
        next_rdata = bank_mask_and_qualifiers[b];
      end
    end
  end

  // Per-bank decode
  generate
    for (genvar g = 0; g < num_banks; g++) begin : g_bank
      logic [15:0] m;
      logic addr_ok, type_ok, wp_ok, use_space; // Decode qualifiers
      // Mask field of this bank
      assign m = bank_mask_and_qualifiers[g][base_mask_hi:base_mask_lo];
      // Masked compare of upper address half
      assign addr_ok = ((access.addr[31:16] ^ bank_base_address[g])
                        & ~m) == 16'h0000;
      // Space masks skipped for alternate master when bit clear;
      // the cpu space mask still applies to every master
      assign use_space = !(access.alt_master &&
        !bank_mask_and_qualifiers[g][alternate_master_pos] &&
        access.kind != acc_cpu_space);
      // Space mask of this access type, when it is used
      assign type_ok = !use_space ||
        !bank_mask_and_qualifiers[g][space_pos(access.kind)];
      // Writes blocked by protection, reads pass
      assign wp_ok = !(access.write &&
        bank_mask_and_qualifiers[g][write_protect_pos]);
      // Valid bank with every qualifier passing
      assign hit[g] = access.valid && addr_ok && type_ok && wp_ok &&
        bank_mask_and_qualifiers[g][valid_pos];
    end
  endgenerate

  // Select output, boot bank overrides while global
  always_comb begin
    if (global_mode) begin // Boot bank follows every access
      // Other banks stay quiet until bank 0 is valid
      next_cs = {7'h00, access.valid};
    end else begin // Programmed decode per bank
      next_cs = hit;
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Reset clears bases, masks and valid bits
      for (int b = 0; b < num_banks; b++) begin
        bank_base_address[b] <= base_reset;
        bank_mask_and_qualifiers[b] <= mask_reset;
      end
      // Outputs quiet, boot mode back
      global_mode <= 1'b1;
      reg_rdata <= 32'h0000_0000;
      chip_select <= 8'h00;
    end else begin
      // Register the next values
      for (int b = 0; b < num_banks; b++) begin
        bank_base_address[b] <= next_base[b];
        bank_mask_and_qualifiers[b] <= next_mask[b];
      end
      global_mode <= next_global;
      reg_rdata <= next_rdata;
      chip_select <= next_cs;
    end
  end

  // Boot mode flag straight from its flip-flop
  assign boot_global = global_mode;

  // Global mode never re-enters without reset
  property p_global_sticky;
    @(posedge clock) disable iff (!nrst)
      !global_mode |=> !global_mode;
  endproperty
  a_global_sticky: assert property (p_global_sticky)
    else $error("global mode re-entered");

  // While global only bank 0 follows access
  property p_global_cs;
    @(posedge clock) disable iff (!nrst)
      global_mode && access.valid |=> chip_select == 8'h01 || !global_mode;
  endproperty
  a_global_cs: assert property (p_global_cs)
    else $error("boot bank not selecting");

  // No select for invalid bank outside global mode
  property p_valid_needed;
    @(posedge clock) disable iff (!nrst)
      !global_mode && !bank_mask_and_qualifiers[2][valid_pos]
      |=> !chip_select[2];
  endproperty
  a_valid_needed: assert property (p_valid_needed)
    else $error("invalid bank selected");

  // Protected write never selects
  property p_wp;
    @(posedge clock) disable iff (!nrst)
      !global_mode && access.write &&
      bank_mask_and_qualifiers[1][write_protect_pos] |=> !chip_select[1];
  endproperty
  a_wp: assert property (p_wp)
    else $error("protected write selected");

  // Address mismatch never selects
  property p_addr;
    @(posedge clock) disable iff (!nrst)
      !global_mode && (((access.addr[31:16] ^ bank_base_address[1]) &
      ~bank_mask_and_qualifiers[1][31:16]) != 16'h0000)
      |=> !chip_select[1];
  endproperty
  a_addr: assert property (p_addr)
    else $error("mismatched address selected");

  // Reset leaves bank 1 invalid
  property p_reset_clear;
    @(posedge clock) !nrst |=> bank_mask_and_qualifiers[1] == mask_reset;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("valid bit survived reset");

  // Full match selects next cycle
  property p_match;
    @(posedge clock) disable iff (!nrst)
      !global_mode && hit[1] |=> chip_select[1];
  endproperty
  a_match: assert property (p_match)
    else $error("matching bank not selected");

  // Masked type on cpu blocks select
  property p_type;
    @(posedge clock) disable iff (!nrst)
      !global_mode && !access.alt_master &&
      bank_mask_and_qualifiers[1][space_pos(access.kind)]
      |=> !chip_select[1];
  endproperty
  a_type: assert property (p_type)
    else $error("masked type selected");

  // Boot bank alone may select while global
  property p_global_others;
    @(posedge clock) disable iff (!nrst)
      global_mode |=> chip_select[7:1] == 7'h00;
  endproperty
  a_global_others: assert property (p_global_others)
    else $error("other bank selected in global mode");

  // Setting bank 0 valid leaves global mode
  property p_global_exit;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr && reg_req.addr == 8'(base_reg_first + mask_reg_delta) &&
      reg_req.wdata[valid_pos] |=> !global_mode;
  endproperty
  a_global_exit: assert property (p_global_exit)
    else $error("global mode kept after valid write");

  // Idle bus never selects
  property p_idle;
    @(posedge clock) disable iff (!nrst)
      !access.valid |=> chip_select == 8'h00;
  endproperty
  a_idle: assert property (p_idle)
    else $error("select without access");

  // Cpu space mask holds for alternate masters too
  property p_cpu_space_alt;
    @(posedge clock) disable iff (!nrst)
      !global_mode && access.alt_master && access.kind == acc_cpu_space &&
      bank_mask_and_qualifiers[1][cpu_space_pos] |=> !chip_select[1];
  endproperty
  a_cpu_space_alt: assert property (p_cpu_space_alt)
    else $error("cpu space mask ignored");

  // Alternate master with bit clear passes space masks
  property p_alt_pass;
    @(posedge clock) disable iff (!nrst)
      !global_mode && access.valid && access.alt_master && !access.write &&
      access.kind != acc_cpu_space &&
      !bank_mask_and_qualifiers[1][alternate_master_pos] &&
      bank_mask_and_qualifiers[1][valid_pos] &&
      ((access.addr[base_mask_hi:base_mask_lo] ^ bank_base_address[1]) &
      ~bank_mask_and_qualifiers[1][base_mask_hi:base_mask_lo]) == 16'h0000
      |=> chip_select[1];
  endproperty
  a_alt_pass: assert property (p_alt_pass)
    else $error("alternate master blocked by space mask");

  // Open access type with full match selects
  property p_open_type;
    @(posedge clock) disable iff (!nrst)
      !global_mode && access.valid && !access.alt_master && !access.write &&
      !bank_mask_and_qualifiers[1][space_pos(access.kind)] &&
      bank_mask_and_qualifiers[1][valid_pos] &&
      ((access.addr[base_mask_hi:base_mask_lo] ^ bank_base_address[1]) &
      ~bank_mask_and_qualifiers[1][base_mask_hi:base_mask_lo]) == 16'h0000
      |=> chip_select[1];
  endproperty
  a_open_type: assert property (p_open_type)
    else $error("open access type not selected");

  // Protected bank still answers reads
  property p_wp_read;
    @(posedge clock) disable iff (!nrst)
      !global_mode && access.valid && !access.alt_master && !access.write &&
      bank_mask_and_qualifiers[1][write_protect_pos] &&
      bank_mask_and_qualifiers[1][valid_pos] &&
      !bank_mask_and_qualifiers[1][space_pos(access.kind)] &&
      ((access.addr[base_mask_hi:base_mask_lo] ^ bank_base_address[1]) &
      ~bank_mask_and_qualifiers[1][base_mask_hi:base_mask_lo]) == 16'h0000
      |=> chip_select[1];
  endproperty
  a_wp_read: assert property (p_wp_read)
    else $error("protected bank refused a read");

  // Reset drops every select and restores global mode
  property p_reset_outputs;
    @(posedge clock) !nrst |=> chip_select == 8'h00 && global_mode;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs)
    else $error("outputs not reset");

  // Base register reads back in the upper half
  property p_base_read;
    @(posedge clock) disable iff (!nrst)
      reg_req.rd && !reg_req.wr &&
      reg_req.addr == 8'(base_reg_first + bank_stride)
      |=> reg_rdata == {$past(bank_base_address[1]), 16'h0000};
  endproperty
  a_base_read: assert property (p_base_read)
    else $error("base register read back wrong");

  // Mask write stores only the writable bits
  property p_mask_store;
    @(posedge clock) disable iff (!nrst)
      reg_req.wr &&
      reg_req.addr == 8'(base_reg_first + bank_stride + mask_reg_delta)
      |=> bank_mask_and_qualifiers[1] ==
      ($past(reg_req.wdata) & mask_reg_writable);
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("mask register stored wrong bits");
endmodule

// *** bus_master_model.sv ***
`timescale 1ns/1ns
module bus_master_model (
  input wire logic clock,
  output cs_decode_pkg::access_t access
);
  import cs_decode_pkg::*;
  // Bus idle at time zero
  initial access = '0;
  // One access held across one rising edge, then released
  task automatic issue(input logic [31:0] a, input logic w, alt,
                       input access_type_t k);
    @(negedge clock);
    access <= '{1'b1, a, w, alt, k};
    @(negedge clock);
    // Released bus drops valid and inverts address, write and master lines; the access type is kept
    access <= '{1'b0, ~a, ~w, ~alt, k};
  endtask
endmodule

// *** tb_chip_select_address_decode.sv ***
`timescale 1ns/1ns
module tb_chip_select_address_decode;
  import cs_decode_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  access_t access;
  logic [7:0] chip_select;
  logic boot_global;
  int fails = 0;
  int checks = 0;
  // Free running clock
  always #4 clock = ~clock;
  cs_decode dut_u (
    .clock(clock),
    .nrst(nrst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .access(access),
    .chip_select(chip_select),
    .boot_global(boot_global)
  );
  bus_master_model master_u (
    .clock(clock),
    .access(access)
  );
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Offset of a bank's base or mask register
  function automatic logic [7:0] reg_at(input int n, input logic m);
    return 8'(base_reg_first + bank_stride * n + (m ? mask_reg_delta : 0));
  endfunction
  // One-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clock);
    reg_req <= '0;
  endtask
  // One-cycle register read, data checked the cycle after
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clock);
    reg_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(negedge clock);
    reg_req <= '0;
    check("reg_rdata", reg_rdata, exp);
  endtask
  // One access, selects checked one cycle later
  task automatic acc(input logic [31:0] a, input logic w, alt,
                     input access_type_t k, input logic [7:0] exp);
    master_u.issue(a, w, alt, k);
    check("chip_select", chip_select, exp);
  endtask
  // Boot bank answers everything before it is valid
  task automatic t_boot;
    check("boot_global", boot_global, 1'b1);
    reg_rd(reg_at(0, 1), 32'h0000_0000);
    acc(32'h1234_5678, 1'b1, 1'b0, acc_user_data, 8'h01);
    reg_wr(reg_at(1, 0), 32'h0200_0000);
    reg_wr(reg_at(1, 1), 32'h0008_0001);
    acc(32'h0200_0000, 1'b0, 1'b0, acc_user_data, 8'h01);
  endtask
  // Programmed decode once bank 0 is valid
  task automatic t_decode;
    reg_wr(reg_at(0, 0), 32'h1000_0000);
    reg_wr(reg_at(0, 1), 32'h0000_0001);
    check("boot_global", boot_global, 1'b0);
    acc(32'h1000_0004, 1'b0, 1'b0, acc_super_data, 8'h01);
    acc(32'h1234_0000, 1'b0, 1'b0, acc_super_data, 8'h00);
    acc(32'h0200_0000, 1'b0, 1'b0, acc_user_data, 8'h02);
    acc(32'h0208_ffff, 1'b0, 1'b0, acc_user_data, 8'h02);
    acc(32'h0201_0000, 1'b0, 1'b0, acc_user_data, 8'h00);
    acc(32'h0210_0000, 1'b0, 1'b0, acc_user_data, 8'h00);
  endtask
  // Write protection blocks writes only
  task automatic t_protect;
    reg_wr(reg_at(1, 1), 32'h0008_0101);
    acc(32'h0200_0010, 1'b1, 1'b0, acc_user_data, 8'h00);
    acc(32'h0200_0010, 1'b0, 1'b0, acc_user_data, 8'h02);
  endtask
  // Each space mask bit, with and without alternate masters
  task automatic t_space;
    logic [31:0] m;
    for (int e = 0; e < 5; e++) begin
      m = 32'h0008_0001 | (32'h0000_0001 << (5 - e));
      reg_wr(reg_at(1, 1), m);
      acc(32'h0200_0000, 1'b0, 1'b0, access_type_t'(e), 8'h00);
      acc(32'h0200_0000, 1'b0, 1'b0, access_type_t'((e + 1) % 5),
          8'h02);
      acc(32'h0200_0000, 1'b0, 1'b1, access_type_t'(e),
          (e == 0) ? 8'h00 : 8'h02);
      reg_wr(reg_at(1, 1), m | 32'h0000_0040);
      acc(32'h0200_0000, 1'b0, 1'b1, access_type_t'(e), 8'h00);
    end
  endtask
  // Readback, reserved bits and an unmapped place
  task automatic t_regs;
    reg_rd(reg_at(1, 0), 32'h0200_0000);
    reg_wr(reg_at(2, 1), 32'hffff_fffe);
    reg_rd(reg_at(2, 1), 32'hffff_017e);
    reg_rd(8'h88, 32'h0000_0000);
    reg_wr(reg_at(2, 0), 32'h4000_0000);
    reg_wr(reg_at(2, 1), 32'h0000_0000);
    acc(32'h4000_0000, 1'b0, 1'b0, acc_user_data, 8'h00);
    reg_wr(reg_at(2, 1), 32'h0000_0001);
    acc(32'h4000_0000, 1'b0, 1'b0, acc_user_data, 8'h04);
  endtask
  // A second reset brings the boot bank back
  task automatic t_rereset;
    @(negedge clock);
    nrst <= 1'b0;
    repeat (2) @(negedge clock);
    nrst <= 1'b1;
    check("boot_global", boot_global, 1'b1);
    reg_rd(reg_at(1, 1), 32'h0000_0000);
    acc(32'h0200_0000, 1'b0, 1'b0, acc_user_data, 8'h01);
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clock);
    nrst <= 1'b1;
    t_boot();
    t_decode();
    t_protect();
    t_space();
    t_regs();
    t_rereset();
    end_of_test();
  end
endmodule
